/* verilog/sss_pkg.sv */
// Constants for the supply start-up sequencer
// Behaviour
// - Start io and core rails once lockout released and enable high.
// - Io and core at 90%: wait first delay, raise power good, start negative rail.
// - After negative gate rail reaches 90%, wait second delay, start analog and half rails.
// - After analog and half rails reach 90%, wait third delay, start positive gate rail.
// - Three delay settings are programmable by the host over the parallel cfg_wr/cfg_addr/cfg_data write port.
// - Io and core rails start in the same cycle; their 90% points within 3ms (not checked: SSS_RAMP_LOW waits for both goods with no limit).
// - Analog and half-analog rails released together so they ramp in step.
// - Each delay is a 3-bit code, 0 to 70 ms in 10 ms steps.
// - Power-up defaults: first delay code 01h, second and third 03h.
// - Delay settings sit at control addresses 07h, 08h, 09h; written per byte.
package sss_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned STEP_MS = 10;
  // Cycles in one 10 ms delay step
  localparam int unsigned STEP_CYC = (CLK_HZ / 1000) * STEP_MS;
  localparam int unsigned IO_CORE_GAP_MS = 3;
  localparam int unsigned CODE_W = 3;
  localparam logic [7:0] ADDR_FIRST_DELAY = 8'h07;
  localparam logic [7:0] ADDR_SECOND_DELAY = 8'h08;
  localparam logic [7:0] ADDR_THIRD_DELAY = 8'h09;
  localparam logic [2:0] FIRST_DELAY_RST = 3'h1;
  localparam logic [2:0] SECOND_DELAY_RST = 3'h3;
  localparam logic [2:0] THIRD_DELAY_RST = 3'h3;
  typedef enum logic [2:0] {
    SSS_IDLE, SSS_RAMP_LOW, SSS_WAIT1, SSS_RAMP_NEG, SSS_WAIT2,
    SSS_RAMP_ANA, SSS_WAIT3, SSS_DONE
  } sss_state_e;
endpackage

/* verilog/sss_sequencer.sv */
// Supply start-up sequencer with programmable step delays
`timescale 1ns/100ps
`default_nettype none
module sss_sequencer #(
  parameter int unsigned STEP_CYC = sss_pkg::STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic input_undervoltage_lockout,
  input wire logic enable,
  input wire logic io_supply_rail_good,
  input wire logic core_supply_rail_good,
  input wire logic negative_gate_rail_good,
  input wire logic analog_supply_rail_good,
  input wire logic half_analog_rail_good,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  output logic io_supply_rail_en,
  output logic core_supply_rail_en,
  output logic power_good_flag,
  output logic negative_gate_rail_en,
  output logic analog_supply_rail_en,
  output logic half_analog_rail_en,
  output logic positive_gate_rail_en,
  output logic seq_done,
  output logic [2:0] first_sequence_delay,
  output logic [2:0] second_sequence_delay,
  output logic [2:0] third_sequence_delay
);
  localparam int unsigned CNT_W = $clog2(STEP_CYC + 1);

  sss_pkg::sss_state_e state_q, state_d;
  logic [CNT_W-1:0] cyc_q, cyc_d;
  logic [2:0] step_q, step_d;
  logic [2:0] first_sequence_delay_d, second_sequence_delay_d, third_sequence_delay_d;
  logic io_en_d, core_en_d, pg_d, neg_en_d;
  logic ana_en_d, half_en_d, pos_en_d, done_d;
  logic run;

  // Delay elapsed once the step count reaches the code
  function automatic logic dly_done(input logic [2:0] steps,
                                    input logic [2:0] code);
    dly_done = (steps == code);
  endfunction

  always_comb begin
    first_sequence_delay_d = first_sequence_delay;
    second_sequence_delay_d = second_sequence_delay;
    third_sequence_delay_d = third_sequence_delay;
    if (cfg_wr) begin
      if (cfg_addr == sss_pkg::ADDR_FIRST_DELAY) begin
        first_sequence_delay_d = cfg_data[2:0];
      end
      if (cfg_addr == sss_pkg::ADDR_SECOND_DELAY) begin
        second_sequence_delay_d = cfg_data[2:0];
      end
      if (cfg_addr == sss_pkg::ADDR_THIRD_DELAY) begin
        third_sequence_delay_d = cfg_data[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_sequence_delay <= sss_pkg::FIRST_DELAY_RST;
      second_sequence_delay <= sss_pkg::SECOND_DELAY_RST;
      third_sequence_delay <= sss_pkg::THIRD_DELAY_RST;
    end else if (clk_en) begin
      first_sequence_delay <= first_sequence_delay_d;
      second_sequence_delay <= second_sequence_delay_d;
      third_sequence_delay <= third_sequence_delay_d;
    end
  end

  assign run = enable && !input_undervoltage_lockout;

  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    step_d = step_q;
    case (state_q)
      sss_pkg::SSS_IDLE: begin
        if (run) begin
          state_d = sss_pkg::SSS_RAMP_LOW;
        end
      end
      sss_pkg::SSS_RAMP_LOW: begin
        if (io_supply_rail_good && core_supply_rail_good) begin
          state_d = sss_pkg::SSS_WAIT1;
        end
      end
      sss_pkg::SSS_RAMP_NEG: begin
        if (negative_gate_rail_good) begin
          state_d = sss_pkg::SSS_WAIT2;
        end
      end
      sss_pkg::SSS_RAMP_ANA: begin
        if (analog_supply_rail_good && half_analog_rail_good) begin
          state_d = sss_pkg::SSS_WAIT3;
        end
      end
      sss_pkg::SSS_WAIT1, sss_pkg::SSS_WAIT2, sss_pkg::SSS_WAIT3: begin
        if ((state_q == sss_pkg::SSS_WAIT1 &&
             dly_done(step_q, first_sequence_delay)) ||
            (state_q == sss_pkg::SSS_WAIT2 &&
             dly_done(step_q, second_sequence_delay)) ||
            (state_q == sss_pkg::SSS_WAIT3 &&
             dly_done(step_q, third_sequence_delay))) begin
          step_d = 3'h0;
          cyc_d = '0;
          case (state_q)
            sss_pkg::SSS_WAIT1: state_d = sss_pkg::SSS_RAMP_NEG;
            sss_pkg::SSS_WAIT2: state_d = sss_pkg::SSS_RAMP_ANA;
            default: state_d = sss_pkg::SSS_DONE;
          endcase
        end else if (cyc_q == CNT_W'(STEP_CYC - 1)) begin
          cyc_d = '0;
          step_d = step_q + 3'h1;
        end else begin
          cyc_d = cyc_q + CNT_W'(1);
        end
      end
      sss_pkg::SSS_DONE: begin
        state_d = sss_pkg::SSS_DONE;
      end
      default: begin
        state_d = sss_pkg::SSS_IDLE;
      end
    endcase
    if (!run) begin
      state_d = sss_pkg::SSS_IDLE;
      cyc_d = '0;
      step_d = 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= sss_pkg::SSS_IDLE;
      cyc_q <= '0;
      step_q <= 3'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      step_q <= step_d;
    end
  end

  // Enables follow the next state, so every output leaves a flop
  always_comb begin
    io_en_d = 1'b0;
    core_en_d = 1'b0;
    pg_d = 1'b0;
    neg_en_d = 1'b0;
    ana_en_d = 1'b0;
    half_en_d = 1'b0;
    pos_en_d = 1'b0;
    done_d = 1'b0;
    case (state_d)
      sss_pkg::SSS_RAMP_LOW, sss_pkg::SSS_WAIT1: begin
        io_en_d = 1'b1;
        core_en_d = 1'b1;
      end
      sss_pkg::SSS_RAMP_NEG, sss_pkg::SSS_WAIT2: begin
        io_en_d = 1'b1;
        core_en_d = 1'b1;
        pg_d = 1'b1;
        neg_en_d = 1'b1;
      end
      sss_pkg::SSS_RAMP_ANA, sss_pkg::SSS_WAIT3: begin
        io_en_d = 1'b1;
        core_en_d = 1'b1;
        pg_d = 1'b1;
        neg_en_d = 1'b1;
        ana_en_d = 1'b1;
        half_en_d = 1'b1;
      end
      sss_pkg::SSS_DONE: begin
        io_en_d = 1'b1;
        core_en_d = 1'b1;
        pg_d = 1'b1;
        neg_en_d = 1'b1;
        ana_en_d = 1'b1;
        half_en_d = 1'b1;
        pos_en_d = 1'b1;
        done_d = 1'b1;
      end
      default: begin
        io_en_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_supply_rail_en <= 1'b0;
      core_supply_rail_en <= 1'b0;
      power_good_flag <= 1'b0;
      negative_gate_rail_en <= 1'b0;
      analog_supply_rail_en <= 1'b0;
      half_analog_rail_en <= 1'b0;
      positive_gate_rail_en <= 1'b0;
      seq_done <= 1'b0;
    end else if (clk_en) begin
      io_supply_rail_en <= io_en_d;
      core_supply_rail_en <= core_en_d;
      power_good_flag <= pg_d;
      negative_gate_rail_en <= neg_en_d;
      analog_supply_rail_en <= ana_en_d;
      half_analog_rail_en <= half_en_d;
      positive_gate_rail_en <= pos_en_d;
      seq_done <= done_d;
    end
  end
endmodule // sss_sequencer
`default_nettype wire

/* bench/sss_sequencer_chk.sv */
// Port checks for the supply start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module sss_sequencer_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic input_undervoltage_lockout,
  input wire logic enable,
  input wire logic negative_gate_rail_good,
  input wire logic analog_supply_rail_good,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic io_supply_rail_en,
  input wire logic core_supply_rail_en,
  input wire logic power_good_flag,
  input wire logic negative_gate_rail_en,
  input wire logic analog_supply_rail_en,
  input wire logic half_analog_rail_en,
  input wire logic positive_gate_rail_en,
  input wire logic seq_done,
  input wire logic [2:0] second_sequence_delay
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_cause: assert property ($rose(io_supply_rail_en) |->
    $past(enable && !input_undervoltage_lockout)) else $error("bad start");
  a_io_core_pair: assert property (
    io_supply_rail_en == core_supply_rail_en) else $error("io core split");
  a_pg_neg_pair: assert property (
    power_good_flag == negative_gate_rail_en) else $error("pg neg split");
  a_pg_order: assert property ($rose(power_good_flag) |->
    $past(io_supply_rail_en, 2)) else $error("pg too early");
  a_ana_pair: assert property (
    analog_supply_rail_en == half_analog_rail_en) else $error("ana split");
  a_ana_order: assert property ($rose(analog_supply_rail_en) |->
    $past(negative_gate_rail_good, 2)) else $error("ana too early");
  a_pos_order: assert property ($rose(positive_gate_rail_en) |->
    seq_done && $past(analog_supply_rail_good, 2)) else $error("pos early");
  a_abort_off: assert property (clk_en && (!enable ||
    input_undervoltage_lockout) |=> !io_supply_rail_en && !power_good_flag
    && !positive_gate_rail_en) else $error("abort ignored");
  a_cfg_write: assert property (clk_en && cfg_wr && cfg_addr == 8'h08 |=>
    second_sequence_delay == $past(cfg_data[2:0])) else $error("cfg lost");
endmodule // sss_sequencer_chk
bind sss_sequencer sss_sequencer_chk sss_sequencer_chk_inst (.*);
`default_nettype wire

/* bench/sss_rail_model.sv */
// Regulators and their threshold comparators
`timescale 1ns/100ps
`default_nettype none
module sss_rail_model #(
  parameter int LAT = 3
) (
  input wire logic clk_sys,
  input wire logic [4:0] en,
  input wire logic [4:0] hold,
  output logic [4:0] good
);
  int cnt [5];
  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) cnt[i] <= en[i] ? cnt[i] + 1 : 0;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) good[i] = en[i] && cnt[i] >= LAT && !hold[i];
  end
endmodule // sss_rail_model
`default_nettype wire

/* bench/sss_sequencer_tb_top.sv */
// Self-checking bench for the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module sss_sequencer_tb_top;
  localparam int S = 4;
  logic clk_sys = 0, rst = 1, clk_en = 1, enable = 0, cfg_wr = 0;
  logic input_undervoltage_lockout = 1;
  logic [7:0] cfg_addr = 8'h00, cfg_data = 8'h00;
  logic [4:0] hold = 5'h00;
  wire logic [4:0] g;
  wire logic io_supply_rail_good, core_supply_rail_good;
  wire logic negative_gate_rail_good, analog_supply_rail_good;
  wire logic half_analog_rail_good;
  logic io_supply_rail_en, core_supply_rail_en, power_good_flag, seq_done;
  logic negative_gate_rail_en, analog_supply_rail_en, half_analog_rail_en;
  logic positive_gate_rail_en;
  logic [2:0] first_sequence_delay, second_sequence_delay, third_sequence_delay;
  int num_errors = 0, checks = 0;
  wire logic [6:0] e = {positive_gate_rail_en, half_analog_rail_en,
    analog_supply_rail_en, negative_gate_rail_en, power_good_flag,
    core_supply_rail_en, io_supply_rail_en};
  assign {half_analog_rail_good, analog_supply_rail_good,
    negative_gate_rail_good, core_supply_rail_good, io_supply_rail_good} = g;
  sss_sequencer #(.STEP_CYC(S)) sss_sequencer_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .input_undervoltage_lockout(input_undervoltage_lockout),
    .enable(enable),
    .io_supply_rail_good(io_supply_rail_good),
    .core_supply_rail_good(core_supply_rail_good),
    .negative_gate_rail_good(negative_gate_rail_good),
    .analog_supply_rail_good(analog_supply_rail_good),
    .half_analog_rail_good(half_analog_rail_good),
    .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr),
    .cfg_data(cfg_data),
    .io_supply_rail_en(io_supply_rail_en),
    .core_supply_rail_en(core_supply_rail_en),
    .power_good_flag(power_good_flag),
    .negative_gate_rail_en(negative_gate_rail_en),
    .analog_supply_rail_en(analog_supply_rail_en),
    .half_analog_rail_en(half_analog_rail_en),
    .positive_gate_rail_en(positive_gate_rail_en),
    .seq_done(seq_done),
    .first_sequence_delay(first_sequence_delay),
    .second_sequence_delay(second_sequence_delay),
    .third_sequence_delay(third_sequence_delay)
  );
  sss_rail_model sss_rail_model_inst (.clk_sys(clk_sys),
    .en({e[5:3], e[1:0]}), .hold(hold), .good(g));
  initial forever #2 clk_sys = ~clk_sys;
  task complete_run;
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp(string n, logic [31:0] x, logic [31:0] y);
    checks++;
    if (y !== x) begin
      num_errors++;
      $display("unexpected %s exp %0h got %0h", n, x, y);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    cfg_addr = a;
    cfg_data = d;
    cfg_wr = 1;
    cyc(1);
    cfg_wr = 0;
    cyc(1);
  endtask
  task span(int gi, int ei, int x);
    int n;
    n = 0;
    while (g[gi] !== 1 && n < 999) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (e[ei] !== 1 && n < 999) begin
      cyc(1);
      n++;
    end
    cmp("span", x, n);
  endtask
  task t_run(int c1, int c2, int c3);
    enable = 1;
    cyc(2);
    cmp("start", 7'h03, e);
    span(0, 2, 2 + c1 * S);
    span(2, 4, 2 + c2 * S);
    span(3, 6, 2 + c3 * S);
    cmp("done", 1, seq_done);
    enable = 0;
    cyc(2);
    cmp("off", 0, e);
  endtask
  task t_cfg;
    wr(8'h07, 8'hf8);
    wr(8'h08, 8'h07);
    wr(8'h09, 8'h02);
    wr(8'h0a, 8'h05);
    wr(8'h06, 8'h06);
    cmp("dly", 9'h03a, {first_sequence_delay, second_sequence_delay,
      third_sequence_delay});
  endtask
  task t_abort;
    hold = 5'h04;
    enable = 1;
    cyc(30);
    cmp("stall", 7'h0f, e);
    input_undervoltage_lockout = 1;
    cyc(2);
    cmp("abort", 0, e);
    hold = 5'h00;
    input_undervoltage_lockout = 0;
    cyc(2);
    cmp("restart", 7'h03, e);
  endtask
  task t_freeze;
    clk_en = 0;
    enable = 0;
    wr(8'h08, 8'h05);
    cmp("frozen", 7'h03, e);
    cmp("frz_dly", 3'h7, second_sequence_delay);
    clk_en = 1;
    cyc(2);
    cmp("thawed", 0, e);
  endtask
  initial begin
    cyc(8);
    rst = 0;
    input_undervoltage_lockout = 0;
    cmp("dflt", 9'h05b, {first_sequence_delay, second_sequence_delay,
      third_sequence_delay});
    t_run(1, 3, 3);
    t_cfg();
    t_run(0, 7, 2);
    t_abort();
    t_freeze();
    complete_run();
  end
  initial begin
    #20000;
    num_errors++;
    complete_run();
  end
endmodule // sss_sequencer_tb_top
`default_nettype wire
